// File: dv/gpp_instr.sv
// bus instrument model: command acceptor, poll talker, parallel responder
`timescale 1ns/1ps
module gpp_instr #(
	parameter logic [4:0] PAD = 5'h05
) (
	// clock
	input wire logic core_clk_i,
	// wired bus, high means asserted
	input wire logic atn_i,
	input wire logic eoi_i,
	input wire logic [7:0] dio_i,
	input wire logic dav_i,
	input wire logic nrfd_i,
	input wire logic ndac_i,
	// scenario controls
	input wire logic [7:0] stb_i,
	input wire logic [7:0] pp_byte_i,
	input wire logic [3:0] lag_i,
	// lines driven by the instrument
	output logic [7:0] dio_o,
	output logic dio_oe_o,
	output logic dav_o,
	output logic nrfd_o,
	output logic ndac_o
);
	logic [7:0] log_q [16];
	int cnt_q = 0;
	logic acc_q = 0, tlk_q = 0, spe_q = 0, sent_q = 0, ppc_q = 1;
	logic [3:0] wait_q = 0;
	initial begin
		dav_o = 1'b0;
		nrfd_o = 1'b0;
		ndac_o = 1'b1;
	end
	// released data lines read as unasserted through the bus pull-ups
	always_comb begin
		dio_oe_o = (atn_i && eoi_i && ppc_q) ||
			(tlk_q && spe_q && !atn_i && !sent_q);
		dio_o = 8'h00;
		if (atn_i && eoi_i && ppc_q)
			dio_o = pp_byte_i;
		else if (dio_oe_o)
			dio_o = stb_i;
	end
	always @(posedge core_clk_i) begin
		if (atn_i) begin
			sent_q <= 1'b0;
			dav_o <= 1'b0;
			if (dav_i && !acc_q) begin
				if (wait_q < lag_i)
					wait_q <= wait_q + 4'h1;
				else begin
					acc_q <= 1'b1;
					nrfd_o <= 1'b1;
					ndac_o <= 1'b0;
					log_q[cnt_q[3:0]] <= dio_i;
					cnt_q <= cnt_q + 1;
					case (dio_i)
						{3'b010, PAD}: tlk_q <= 1'b1;
						8'h5f: tlk_q <= 1'b0;
						8'h18: spe_q <= 1'b1;
						8'h19: spe_q <= 1'b0;
						8'h15: ppc_q <= 1'b0;
						default: ;
					endcase
				end
			end else if (!dav_i) begin
				acc_q <= 1'b0;
				wait_q <= 4'h0;
				nrfd_o <= 1'b0;
				ndac_o <= 1'b1;
			end
		end else begin
			nrfd_o <= 1'b0;
			ndac_o <= 1'b0;
			acc_q <= 1'b0;
			// ndac must come from a listener, not our own last accept
			if (dio_oe_o && !dav_o && !nrfd_i && ndac_i && !ndac_o)
				dav_o <= 1'b1;
			else if (dav_o && !ndac_i) begin
				dav_o <= 1'b0;
				sent_q <= 1'b1;
			end
		end
	end
endmodule

// File: dv/gpp_poll_chk.sv
// concurrent checks on the ports of the poll and addressing block
`timescale 1ns/1ps
module gpp_poll_chk #(
	parameter int IFC_CYCLES = 8,
	parameter int PP_SETTLE_CYCLES = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// host side
	input wire logic run_parallel_poll_i,
	input wire logic set_own_poll_status_i,
	input wire logic system_control_request_i,
	input wire logic pulse_interface_clear_i,
	input wire logic drive_remote_enable_i,
	input wire logic set_secondary_address_i,
	input wire logic [7:0] op_value_i,
	input wire logic sad_for_board_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [1:0] error_code_o,
	input wire logic [7:0] resp_byte_o,
	input wire logic sys_ctrl_o,
	input wire logic cic_o,
	input wire logic board_ext_addr_o,
	// bus side
	input wire logic ifc_i,
	input wire logic [7:0] dio_i,
	input wire logic atn_o,
	input wire logic eoi_o,
	input wire logic ifc_o,
	input wire logic ren_o,
	input wire logic srq_o
);
	logic hi, pp_go, sad_go, ok_sad;
	// higher-priority requests in the same cycle mask the lower ones
	assign hi = pulse_interface_clear_i | system_control_request_i |
		drive_remote_enable_i;
	assign pp_go = run_parallel_poll_i && !busy_o && !hi &&
		!set_own_poll_status_i && !set_secondary_address_i;
	assign sad_go = set_secondary_address_i && sad_for_board_i &&
		!busy_o && !hi && !set_own_poll_status_i;
	assign ok_sad = op_value_i inside {[8'h60:8'h7e], 8'h00, 8'h7f};

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_idy_pair: assert property (eoi_o |-> atn_o)
		else $error("eoi asserted without atn");
	a_pp_timing: assert property (
		pp_go && cic_o |=> atn_o && busy_o ##1 eoi_o
		##PP_SETTLE_CYCLES done_o && atn_o && !eoi_o)
		else $error("parallel poll sequence or timing wrong");
	a_pp_sample: assert property (
		$fell(eoi_o) |-> done_o && resp_byte_o == $past(dio_i))
		else $error("parallel poll byte not the sampled lines");
	a_pp_refuse: assert property (
		pp_go && !cic_o |=> done_o && error_code_o == 2'h1 && !atn_o)
		else $error("parallel poll not refused");
	a_srq_follow: assert property (
		set_own_poll_status_i && !busy_o && !hi
		|=> srq_o == $past(op_value_i[6]))
		else $error("srq does not follow status bit 6");
	a_ifc_run: assert property (
		pulse_interface_clear_i && !busy_o && sys_ctrl_o
		|=> ifc_o ##IFC_CYCLES done_o && cic_o)
		else $error("interface clear pulse wrong");
	a_ifc_refuse: assert property (
		pulse_interface_clear_i && !busy_o && !sys_ctrl_o
		|=> done_o && error_code_o == 2'h2 && !ifc_o)
		else $error("interface clear not refused");
	a_ren_needs_sc: assert property (ren_o |-> sys_ctrl_o)
		else $error("remote enable without system control");
	a_foreign_ifc: assert property (
		ifc_i && !sys_ctrl_o && !busy_o |=> !cic_o)
		else $error("foreign clear not obeyed");
	a_sad_set: assert property (
		sad_go && op_value_i inside {[8'h60:8'h7e]}
		|=> done_o && board_ext_addr_o && error_code_o == 2'h0)
		else $error("secondary address not enabled");
	a_sad_off: assert property (
		sad_go && (op_value_i == 8'h00 || op_value_i == 8'h7f)
		|=> done_o && !board_ext_addr_o)
		else $error("secondary address not disabled");
	a_sad_bad: assert property (
		sad_go && !ok_sad
		|=> error_code_o == 2'h3 && $stable(board_ext_addr_o))
		else $error("bad secondary address accepted");
endmodule

bind gpp_poll gpp_poll_chk #(.IFC_CYCLES(IFC_CYCLES),
	.PP_SETTLE_CYCLES(PP_SETTLE_CYCLES)) u_chk (.*);

// File: dv/ieee488_poll_and_addressing_tb_top.sv
// self-checking bench for the poll and addressing block
`timescale 1ns/1ps
module ieee488_poll_and_addressing_tb_top;
	logic core_clk_i = 0, rst_b_i = 0, pp_dev = 0, auto_en = 0;
	logic sad_brd = 1, ifc_ext = 0, busy, done, sys, cic, ext;
	logic atn, eoi, ifc, ren, srq, oe_d, oe_p, dav_d, dav_p;
	logic nrfd_d, nrfd_p, ndac_d, ndac_p;
	logic [6:0] req = '0;
	logic [4:0] pad = 5'h05, bpad = 5'h00;
	logic [1:0] dev_idx = 0, err;
	logic [7:0] val = 0, stb = 0, ppb = 0, resp, dio_d, dio_p, dio_w;
	logic [3:0] lag = 0, flag;
	int bad_count = 0, compares = 0, cyc = 0;
	assign dio_w = (oe_d ? dio_d : 8'h00) | (oe_p ? dio_p : 8'h00);

	gpp_poll #(.NDEV(4), .IW(2), .IFC_CYCLES(8), .PP_SETTLE_CYCLES(4)) uut (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.run_parallel_poll_i(req[0]), .pp_for_device_i(pp_dev),
		.read_serial_poll_byte_i(req[1]), .set_own_poll_status_i(req[2]),
		.system_control_request_i(req[3]),
		.pulse_interface_clear_i(req[4]), .drive_remote_enable_i(req[5]),
		.set_secondary_address_i(req[6]), .dev_index_i(dev_idx),
		.dev_pad_i(pad), .board_pad_i(bpad), .auto_poll_en_i(auto_en),
		.op_value_i(val), .sad_for_board_i(sad_brd), .busy_o(busy),
		.done_o(done), .error_code_o(err), .resp_byte_o(resp),
		.sys_ctrl_o(sys), .cic_o(cic), .board_ext_addr_o(ext),
		.request_service_flag_o(flag), .atn_o(atn), .eoi_o(eoi),
		.ifc_o(ifc), .ifc_i(ifc_ext), .ren_o(ren), .srq_o(srq),
		.dio_i(dio_w), .dio_o(dio_d), .dio_oe_o(oe_d),
		.dav_i(dav_d | dav_p), .dav_o(dav_d), .nrfd_i(nrfd_d | nrfd_p),
		.nrfd_o(nrfd_d), .ndac_i(ndac_d | ndac_p), .ndac_o(ndac_d));

	gpp_instr #(.PAD(5'h05)) inst (
		.core_clk_i(core_clk_i), .atn_i(atn), .eoi_i(eoi), .dio_i(dio_w),
		.dav_i(dav_d | dav_p), .nrfd_i(nrfd_d | nrfd_p),
		.ndac_i(ndac_d | ndac_p), .stb_i(stb), .pp_byte_i(ppb),
		.lag_i(lag), .dio_o(dio_p), .dio_oe_o(oe_p), .dav_o(dav_p),
		.nrfd_o(nrfd_p), .ndac_o(ndac_p));

	always #12.5 core_clk_i = ~core_clk_i;

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one host request pulse, then wait for its completion strobe
	task automatic op(input int k, input logic [7:0] v);
		@(negedge core_clk_i);
		val = v;
		req[k] = 1'b1;
		@(negedge core_clk_i);
		req = '0;
		while (done !== 1'b1) @(negedge core_clk_i);
	endtask
	task automatic pulse_ext_ifc();
		@(negedge core_clk_i);
		ifc_ext = 1'b1;
		@(negedge core_clk_i);
		ifc_ext = 1'b0;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_refuse();
		op(0, 8'h00);
		chk("pp not cic", {atn, err}, 3'h1);
		op(4, 8'h00);
		chk("ifc no sc", {ifc, err}, 3'h2);
		op(5, 8'h01);
		chk("ren no sc", {ren, err}, 3'h2);
		$display("test refuse done");
	endtask
	task automatic t_ctrl();
		op(3, 8'h01);
		chk("sc on", sys, 1'b1);
		op(5, 8'h01);
		chk("ren on", {ren, err}, 3'h4);
		op(4, 8'h00);
		chk("ifc cic", {cic, err}, 3'h4);
		pulse_ext_ifc();
		chk("ext ifc ignored", cic, 1'b1);
		$display("test ctrl done");
	endtask
	task automatic t_pp();
		ppb = 8'h5a;
		op(0, 8'h00);
		chk("pp byte", resp, 8'h5a);
		chk("pp lines", {atn, eoi, err}, 4'h8);
		pp_dev = 1'b1;
		dev_idx = 2'h3;
		ppb = 8'ha5;
		op(0, 8'h00);
		chk("pp device form", resp, 8'ha5);
		pp_dev = 1'b0;
		$display("test pp done");
	endtask
	task automatic t_own();
		op(2, 8'h41);
		chk("srq set", srq, 1'b1);
		op(2, 8'h01);
		chk("srq clear", srq, 1'b0);
		$display("test own done");
	endtask
	task automatic t_sad();
		logic [7:0] v [7] = '{8'h6a, 8'h7f, 8'h60, 8'h00, 8'h7e, 8'h5f, 8'h80};
		logic [2:0] e [7] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h4, 3'h7, 3'h7};
		for (int i = 0; i < 7; i++) begin
			op(6, v[i]);
			chk("sad ext err", {ext, err}, e[i]);
		end
		sad_brd = 1'b0;
		dev_idx = 2'h1;
		op(6, 8'h6a);
		chk("dev sad err", err, 2'h0);
		sad_brd = 1'b1;
		$display("test sad done");
	endtask
	task automatic t_sp();
		logic [7:0] x [9] = '{8'h3f, 8'h45, 8'h6a, 8'h20, 8'h7e, 8'h18,
			8'h5f, 8'h3f, 8'h19};
		stb = 8'h42;
		lag = 4'h2;
		op(1, 8'h00);
		chk("sp byte", resp, 8'h42);
		chk("sp flag", flag[1], 1'b1);
		chk("sp count", 16'(inst.cnt_q), 16'h0009);
		for (int i = 0; i < 9; i++)
			chk("sp cmd", inst.log_q[i], x[i]);
		auto_en = 1'b1;
		stb = 8'h10;
		lag = 4'h0;
		op(1, 8'h00);
		chk("cached byte", resp, 8'h42);
		chk("no bus traffic", 16'(inst.cnt_q), 16'h0009);
		op(1, 8'h00);
		chk("fresh byte", resp, 8'h10);
		chk("fresh count", 16'(inst.cnt_q), 16'h0012);
		chk("flag clear", flag[1], 1'b0);
		$display("test sp done");
	endtask
	task automatic t_foreign();
		op(3, 8'h00);
		chk("sc off", {sys, ren}, 2'h0);
		pulse_ext_ifc();
		chk("ext ifc obeyed", cic, 1'b0);
		op(0, 8'h00);
		chk("pp after loss", err, 2'h1);
		$display("test foreign done");
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		t_refuse();
		t_ctrl();
		t_pp();
		t_own();
		t_sad();
		t_sp();
		t_foreign();
		stop_test();
	end
endmodule

// File: src/gpp_defs.svh
// constants of the poll and addressing block: command bytes, limits, timing
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// ****************************************************************
// bus command bytes, sent with atn asserted
// ****************************************************************
`define GPP_CMD_UNL 8'h3f
`define GPP_CMD_UNT 8'h5f
`define GPP_CMD_SPE 8'h18
`define GPP_CMD_SPD 8'h19
`define GPP_CMD_PPU 8'h15
`define GPP_TALK_BASE 8'h40
`define GPP_LISTEN_BASE 8'h20

// ****************************************************************
// status byte and secondary address fields
// ****************************************************************
`define GPP_RQS_BIT 6
`define GPP_SAD_MIN 8'h60
`define GPP_SAD_MAX 8'h7e
`define GPP_SAD_OFF 8'h7f
`define GPP_OWN_STB_RST 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define GPP_CLK_MHZ 40
`define GPP_IFC_NS 100000
`define GPP_IFC_CYC ((`GPP_IFC_NS * `GPP_CLK_MHZ + 999) / 1000)
`define GPP_PP_SETTLE_NS 2000
`define GPP_PP_SETTLE_CYC ((`GPP_PP_SETTLE_NS * `GPP_CLK_MHZ + 999) / 1000)

`endif

// File: src/gpp_hs.sv
// three-wire byte handshake engine: source for commands, acceptor for data
`timescale 1ns/1ps
module gpp_hs (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// request channel
	gpp_xfer_if.eng x,
	// data lines
	input wire logic [7:0] dio_i,
	output logic [7:0] dio_o,
	output logic dio_oe_o,
	// handshake lines, high means asserted
	input wire logic dav_i,
	output logic dav_o,
	input wire logic nrfd_i,
	output logic nrfd_o,
	input wire logic ndac_i,
	output logic ndac_o
);
	gpp_pkg::gpp_hs_state_t st_q;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_q <= gpp_pkg::HS_IDLE;
			dio_o <= 8'h00;
			dio_oe_o <= 1'b0;
			dav_o <= 1'b0;
			nrfd_o <= 1'b0;
			ndac_o <= 1'b0;
			x.done <= 1'b0;
			x.rx_byte <= 8'h00;
		end else begin
			x.done <= 1'b0;
			case (st_q)
				gpp_pkg::HS_IDLE: begin
					if (x.go && x.rd) begin
						// listener: ready for data, not yet accepted
						nrfd_o <= 1'b0;
						ndac_o <= 1'b1;
						st_q <= gpp_pkg::HS_ACC_WAIT;
					end else if (x.go) begin
						dio_o <= x.tx_byte;
						dio_oe_o <= 1'b1;
						st_q <= gpp_pkg::HS_SRC_WAIT;
					end
				end
				gpp_pkg::HS_SRC_WAIT: begin
					if (!nrfd_i) begin
						dav_o <= 1'b1;
						st_q <= gpp_pkg::HS_SRC_DAV;
					end
				end
				gpp_pkg::HS_SRC_DAV: begin
					if (!ndac_i) begin
						dav_o <= 1'b0;
						dio_oe_o <= 1'b0;
						x.done <= 1'b1;
						st_q <= gpp_pkg::HS_IDLE;
					end
				end
				gpp_pkg::HS_ACC_WAIT: begin
					if (dav_i) begin
						x.rx_byte <= dio_i;
						nrfd_o <= 1'b1;
						ndac_o <= 1'b0;
						st_q <= gpp_pkg::HS_ACC_HOLD;
					end
				end
				gpp_pkg::HS_ACC_HOLD: begin
					// exactly one byte: hold off further data until idle
					if (!dav_i) begin
						nrfd_o <= 1'b0;
						x.done <= 1'b1;
						st_q <= gpp_pkg::HS_IDLE;
					end
				end
				default: st_q <= gpp_pkg::HS_IDLE;
			endcase
		end
	end
endmodule

// File: src/gpp_pkg.sv
// types shared by the poll and addressing block
package gpp_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_IFC = 4'b0001,
		ST_PP_TAKE = 4'b0010,
		ST_PP_SETTLE = 4'b0011,
		ST_SP_CMD = 4'b0100,
		ST_SP_WAIT = 4'b0101,
		ST_SP_READ = 4'b0110,
		ST_SP_RWAIT = 4'b0111,
		ST_SP_TAIL = 4'b1000,
		ST_SP_TWAIT = 4'b1001
	} gpp_state_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SRC_WAIT = 3'b001,
		HS_SRC_DAV = 3'b010,
		HS_ACC_WAIT = 3'b011,
		HS_ACC_HOLD = 3'b100
	} gpp_hs_state_t;

	typedef enum logic [1:0] {
		ERR_NONE = 2'b00,
		ERR_NOT_CIC = 2'b01,
		ERR_NO_SYSCTL = 2'b10,
		ERR_BAD_ARG = 2'b11
	} gpp_err_t;

endpackage

// File: src/gpp_poll.sv
// controller polling, own poll status, system control and secondary address
// Contract
// - parallel poll drives atn and eoi together as the identify message
// - data lines sampled during identify become the parallel poll byte
// - parallel poll when not controller-in-charge is refused with an error
// - standby controller takes control with ifc first, stays active after
// - a per-device parallel poll runs as the full board poll
// - status bit 6 set means the device requests service
// - serial poll sends unlisten, talk, device secondary, listen, board secondary, then enable
// - after enable exactly one response byte is read
// - after the byte send untalk, unlisten, serial poll disable
// - automatic polling returns the stored byte when its flag is set
// - programmable own status byte; srq follows its bit 6
// - system control setting permits or forbids clear and remote enable
// - outside interface clear obeyed only without system control
// - secondary address in range is stored and enables extended addressing
// - zero or 0x7f disables extended addressing
// - stored device secondary follows its primary in addressing
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_poll #(
	parameter int NDEV = 4,
	parameter int IW = 2,
	parameter int IFC_CYCLES = `GPP_IFC_CYC,
	parameter int PP_SETTLE_CYCLES = `GPP_PP_SETTLE_CYC
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// host operations, one-cycle pulses
	input wire logic run_parallel_poll_i,
	input wire logic pp_for_device_i,
	input wire logic read_serial_poll_byte_i,
	input wire logic set_own_poll_status_i,
	input wire logic system_control_request_i,
	input wire logic pulse_interface_clear_i,
	input wire logic drive_remote_enable_i,
	input wire logic set_secondary_address_i,
	// host operation arguments
	input wire logic [IW-1:0] dev_index_i,
	input wire logic [4:0] dev_pad_i,
	input wire logic [4:0] board_pad_i,
	input wire logic auto_poll_en_i,
	input wire logic [7:0] op_value_i,
	input wire logic sad_for_board_i,
	// host results
	output logic busy_o,
	output logic done_o,
	output logic [1:0] error_code_o,
	output logic [7:0] resp_byte_o,
	output logic sys_ctrl_o,
	output logic cic_o,
	output logic board_ext_addr_o,
	output logic [NDEV-1:0] request_service_flag_o,
	// bus control lines, high means asserted
	output logic atn_o,
	output logic eoi_o,
	output logic ifc_o,
	input wire logic ifc_i,
	output logic ren_o,
	output logic srq_o,
	// bus data and handshake
	input wire logic [7:0] dio_i,
	output logic [7:0] dio_o,
	output logic dio_oe_o,
	input wire logic dav_i,
	output logic dav_o,
	input wire logic nrfd_i,
	output logic nrfd_o,
	input wire logic ndac_i,
	output logic ndac_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	gpp_pkg::gpp_state_t st_q;
	logic [2:0] step_q;
	logic [12:0] cnt_q;
	logic [IW-1:0] idx_q;
	logic [4:0] pad_q;
	logic [7:0] own_stb_q;
	logic [6:0] dev_sad_q [NDEV];
	logic [NDEV-1:0] dev_sad_en_q;
	logic [6:0] brd_sad_q;
	logic [7:0] cache_q [NDEV];
	logic [8:0] head_w;
	logic [7:0] tail_w;
	logic idle_w;
	logic acc_ifc, acc_sysctl, acc_own, acc_ren, acc_sad, acc_pp, acc_sp;
	logic [6:0] req_w;
	logic sad_on_w, sad_off_w;
	logic ifc_ok_w, ren_ok_w, cache_hit_w;

	gpp_xfer_if xf ();

	gpp_hs u_hs (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.x(xf.eng),
		.dio_i(dio_i),
		.dio_o(dio_o),
		.dio_oe_o(dio_oe_o),
		.dav_i(dav_i),
		.dav_o(dav_o),
		.nrfd_i(nrfd_i),
		.nrfd_o(nrfd_o),
		.ndac_i(ndac_i),
		.ndac_o(ndac_o)
	);

	// ****************************************************************
	// command byte sequences
	// ****************************************************************
	// head of a serial poll; bit 8 clear means the step is skipped
	function automatic logic [8:0] head_byte(input logic [2:0] s,
		input logic [4:0] dpad, input logic [4:0] bpad,
		input logic den, input logic [6:0] dsad,
		input logic ben, input logic [6:0] bsad);
		logic [8:0] r;
		r = 9'h000;
		case (s)
			3'd0: r = {1'b1, `GPP_CMD_UNL};
			3'd1: r = {1'b1, `GPP_TALK_BASE | {3'b000, dpad}};
			3'd2: r = {den, 1'b0, dsad};
			3'd3: r = {1'b1, `GPP_LISTEN_BASE | {3'b000, bpad}};
			3'd4: r = {ben, 1'b0, bsad};
			3'd5: r = {1'b1, `GPP_CMD_SPE};
			default: r = 9'h000;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] tail_byte(input logic [2:0] s);
		logic [7:0] r;
		r = `GPP_CMD_SPD;
		case (s)
			3'd0: r = `GPP_CMD_UNT;
			3'd1: r = `GPP_CMD_UNL;
			default: r = `GPP_CMD_SPD;
		endcase
		return r;
	endfunction

	assign head_w = head_byte(step_q, pad_q, board_pad_i,
		dev_sad_en_q[idx_q], dev_sad_q[idx_q],
		board_ext_addr_o, brd_sad_q);
	assign tail_w = tail_byte(step_q);

	// ****************************************************************
	// request acceptance, one operation at a time by fixed priority
	// ****************************************************************
	assign idle_w = (st_q == gpp_pkg::ST_IDLE);
	// lowest set bit wins: clear first, serial poll last
	assign req_w = {read_serial_poll_byte_i, run_parallel_poll_i,
		set_secondary_address_i, set_own_poll_status_i,
		drive_remote_enable_i, system_control_request_i,
		pulse_interface_clear_i};
	assign {acc_sp, acc_pp, acc_sad, acc_own, acc_ren, acc_sysctl,
		acc_ifc} = idle_w ? (req_w & (~req_w + 7'h01)) : 7'h00;

	assign sad_on_w = (op_value_i >= `GPP_SAD_MIN) &&
		(op_value_i <= `GPP_SAD_MAX);
	assign sad_off_w = (op_value_i == 8'h00) ||
		(op_value_i == `GPP_SAD_OFF);
	assign ifc_ok_w = sys_ctrl_o;
	assign ren_ok_w = sys_ctrl_o;
	assign cache_hit_w = auto_poll_en_i &&
		request_service_flag_o[dev_index_i];

	// ****************************************************************
	// sequencer: controller state, bus control lines and results
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_q <= gpp_pkg::ST_IDLE;
			step_q <= 3'd0;
			cnt_q <= 13'h0000;
			idx_q <= '0;
			pad_q <= 5'h00;
			atn_o <= 1'b0;
			eoi_o <= 1'b0;
			ifc_o <= 1'b0;
			cic_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			error_code_o <= gpp_pkg::ERR_NONE;
			resp_byte_o <= 8'h00;
			xf.go <= 1'b0;
			xf.rd <= 1'b0;
			xf.tx_byte <= 8'h00;
		end else begin
			done_o <= 1'b0;
			xf.go <= 1'b0;
			case (st_q)
				gpp_pkg::ST_IDLE: begin
					if (acc_ifc && !ifc_ok_w) begin
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NO_SYSCTL;
					end else if (acc_ifc) begin
						ifc_o <= 1'b1;
						cnt_q <= 13'(IFC_CYCLES - 1);
						busy_o <= 1'b1;
						st_q <= gpp_pkg::ST_IFC;
					end else if (acc_ren) begin
						done_o <= 1'b1;
						error_code_o <= ren_ok_w ? gpp_pkg::ERR_NONE :
							gpp_pkg::ERR_NO_SYSCTL;
					end else if (acc_sysctl || acc_own) begin
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NONE;
					end else if (acc_sad) begin
						done_o <= 1'b1;
						error_code_o <= (sad_on_w || sad_off_w) ?
							gpp_pkg::ERR_NONE : gpp_pkg::ERR_BAD_ARG;
					end else if (acc_pp && !cic_o) begin
						// refused without touching the bus
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NOT_CIC;
					end else if (acc_pp) begin
						// device form is the same board-wide poll
						atn_o <= 1'b1;
						busy_o <= 1'b1;
						st_q <= gpp_pkg::ST_PP_TAKE;
					end else if (acc_sp && cache_hit_w) begin
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NONE;
						resp_byte_o <= cache_q[dev_index_i];
					end else if (acc_sp && !cic_o) begin
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NOT_CIC;
					end else if (acc_sp) begin
						atn_o <= 1'b1;
						idx_q <= dev_index_i;
						pad_q <= dev_pad_i;
						step_q <= 3'd0;
						busy_o <= 1'b1;
						st_q <= gpp_pkg::ST_SP_CMD;
					end
				end
				gpp_pkg::ST_IFC: begin
					if (cnt_q == 13'h0000) begin
						// bus is ours: controller-in-charge, active
						ifc_o <= 1'b0;
						cic_o <= 1'b1;
						atn_o <= 1'b1;
						busy_o <= 1'b0;
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NONE;
						st_q <= gpp_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 13'h0001;
					end
				end
				gpp_pkg::ST_PP_TAKE: begin
					// atn already up one cycle before eoi joins it
					eoi_o <= 1'b1;
					cnt_q <= 13'(PP_SETTLE_CYCLES - 1);
					st_q <= gpp_pkg::ST_PP_SETTLE;
				end
				gpp_pkg::ST_PP_SETTLE: begin
					if (cnt_q == 13'h0000) begin
						resp_byte_o <= dio_i;
						eoi_o <= 1'b0;
						busy_o <= 1'b0;
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NONE;
						st_q <= gpp_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 13'h0001;
					end
				end
				gpp_pkg::ST_SP_CMD: begin
					if (head_w[8]) begin
						xf.go <= 1'b1;
						xf.rd <= 1'b0;
						xf.tx_byte <= head_w[7:0];
						st_q <= gpp_pkg::ST_SP_WAIT;
					end else begin
						step_q <= step_q + 3'd1;
					end
				end
				gpp_pkg::ST_SP_WAIT: begin
					if (xf.done && step_q == 3'd5) begin
						atn_o <= 1'b0;
						st_q <= gpp_pkg::ST_SP_READ;
					end else if (xf.done) begin
						step_q <= step_q + 3'd1;
						st_q <= gpp_pkg::ST_SP_CMD;
					end
				end
				gpp_pkg::ST_SP_READ: begin
					xf.go <= 1'b1;
					xf.rd <= 1'b1;
					st_q <= gpp_pkg::ST_SP_RWAIT;
				end
				gpp_pkg::ST_SP_RWAIT: begin
					if (xf.done) begin
						resp_byte_o <= xf.rx_byte;
						atn_o <= 1'b1;
						step_q <= 3'd0;
						st_q <= gpp_pkg::ST_SP_TAIL;
					end
				end
				gpp_pkg::ST_SP_TAIL: begin
					xf.go <= 1'b1;
					xf.rd <= 1'b0;
					xf.tx_byte <= tail_w;
					st_q <= gpp_pkg::ST_SP_TWAIT;
				end
				gpp_pkg::ST_SP_TWAIT: begin
					if (xf.done && step_q == 3'd2) begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
						error_code_o <= gpp_pkg::ERR_NONE;
						st_q <= gpp_pkg::ST_IDLE;
					end else if (xf.done) begin
						step_q <= step_q + 3'd1;
						st_q <= gpp_pkg::ST_SP_TAIL;
					end
				end
				default: st_q <= gpp_pkg::ST_IDLE;
			endcase
			// a foreign clear only strips control while idle; a running
			// sequence finishes first, which keeps atn and eoi paired unless the clear lands in the cycle a parallel poll is accepted
			if (ifc_i && !sys_ctrl_o && idle_w) begin
				cic_o <= 1'b0;
				atn_o <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// configuration: system control, remote enable, own status byte
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			sys_ctrl_o <= 1'b0;
			ren_o <= 1'b0;
			own_stb_q <= `GPP_OWN_STB_RST;
			srq_o <= 1'b0;
		end else begin
			if (acc_sysctl) begin
				sys_ctrl_o <= |op_value_i;
				// losing system control forbids remote enable too
				if (op_value_i == 8'h00) begin
					ren_o <= 1'b0;
				end
			end
			if (acc_ren && ren_ok_w) begin
				ren_o <= |op_value_i;
			end
			if (acc_own) begin
				own_stb_q <= op_value_i;
				srq_o <= op_value_i[`GPP_RQS_BIT];
			end
		end
	end

	// ****************************************************************
	// secondary addresses of the board and each device
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			brd_sad_q <= 7'h00;
			board_ext_addr_o <= 1'b0;
			dev_sad_en_q <= '0;
			for (int i = 0; i < NDEV; i++) begin
				dev_sad_q[i] <= 7'h00;
			end
		end else if (acc_sad && sad_on_w && sad_for_board_i) begin
			brd_sad_q <= op_value_i[6:0];
			board_ext_addr_o <= 1'b1;
		end else if (acc_sad && sad_off_w && sad_for_board_i) begin
			board_ext_addr_o <= 1'b0;
		end else if (acc_sad && sad_on_w) begin
			dev_sad_q[dev_index_i] <= op_value_i[6:0];
			dev_sad_en_q[dev_index_i] <= 1'b1;
		end else if (acc_sad && sad_off_w) begin
			dev_sad_en_q[dev_index_i] <= 1'b0;
		end
	end

	// ****************************************************************
	// serial poll cache with request-service flags
	// ****************************************************************
	// a fresh positive answer sets the flag; handing back a stored byte
	// consumes it, so the next call polls the device again
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			request_service_flag_o <= '0;
			for (int i = 0; i < NDEV; i++) begin
				cache_q[i] <= 8'h00;
			end
		end else if (st_q == gpp_pkg::ST_SP_RWAIT && xf.done) begin
			cache_q[idx_q] <= xf.rx_byte;
			request_service_flag_o[idx_q] <=
				xf.rx_byte[`GPP_RQS_BIT];
		end else if (acc_sp && cache_hit_w) begin
			request_service_flag_o[dev_index_i] <= 1'b0;
		end
	end

	// own_stb_q drives nothing but unused_w; no logic puts it on the bus for a foreign controller
	logic unused_w;
	assign unused_w = ^own_stb_q ^ pp_for_device_i;
endmodule

// File: src/gpp_xfer_if.sv
// byte transfer request channel between sequencer and handshake engine
`timescale 1ns/1ps
interface gpp_xfer_if;
	logic go;
	logic rd;
	logic [7:0] tx_byte;
	logic done;
	logic [7:0] rx_byte;

	modport ctl(output go, output rd, output tx_byte,
		input done, input rx_byte);
	modport eng(input go, input rd, input tx_byte,
		output done, output rx_byte);
endinterface
